/* logic/apm_cfg.svh */
// Notes on behaviour
// - mode 0: powered while select low
// - host waits 5 us before sampling edge
// - normal mode: always powered
// - host resends normal code every transfer
// - normal mode: back-to-back transfers allowed
// - auto-shutdown after each conversion
// - auto-shutdown wakes on first falling clock
// - host uses normal mode as warm-up
// - auto-standby after conversion, quick wake
// - standby entered on last rising edge
// - select low gates clock, tracks input
// - second rising edge samples and converts
// - sixteen clocks per transfer
// - select high floats data output
// - channel taken from previous control write
// - first eight rising edges load control
// - read-only host holds data input low
// - shift on falling, capture on rising
// - four zeros then twelve bits msb first
// - start in select-controlled mode
// - mode 0: select high mid-conversion shuts down
`ifndef APM_CFG_SVH
`define APM_CFG_SVH
`define APM_CTRL_BITS 8
`define APM_WORD_BITS 16
`define APM_RESULT_BITS 12
`define APM_PM_HI_POS 1
`define APM_PM_LO_POS 0
`define APM_CHAN_POS 5
`define APM_CTRL_RESET 8'h00
`define APM_SAMPLE_EDGE 5'h02
`define APM_LAST_EDGE 5'h10
`define APM_WAKE_NS 5000
`define APM_CLK_NS 10
`define APM_WAKE_CYC ((`APM_WAKE_NS + `APM_CLK_NS - 1) / `APM_CLK_NS)
`define APM_HALF_DIV 8
`endif

/* logic/apm_pkg.sv */
package apm_pkg;
  typedef enum logic [1:0]
  {
    APM_SEL_CTRL = 2'b00,
    APM_NORMAL = 2'b01,
    APM_AUTO_SHUT = 2'b10,
    APM_AUTO_STBY = 2'b11
  } apm_mode_e;
  typedef enum logic [1:0]
  {
    APM_OFF = 2'b00,
    APM_STANDBY = 2'b01,
    APM_ON = 2'b10
  } apm_power_e;
endpackage : apm_pkg

/* logic/apm_link_if.sv */
`timescale 1ns/1ps
interface apm_link_if;
  logic selectN;
  logic serialClk;
  logic dataIn;
  logic dataOut;
  logic dataOutEn;
  modport device (input selectN, input serialClk, input dataIn, output dataOut, output dataOutEn);
  modport host (output selectN, output serialClk, output dataIn, input dataOut, input dataOutEn);
endinterface : apm_link_if

/* logic/apm_device.sv */
`timescale 1ns/1ps
`include "apm_cfg.svh"
module apm_device
(
  input wire logic clk,
  input wire logic reset,
  apm_link_if.device link,
  input wire logic [11:0] sampleA,
  input wire logic [11:0] sampleB,
  output logic [1:0] powerState,
  output logic [1:0] powerMode,
  output logic tracking,
  output logic converting,
  output logic [7:0] ctrlValue
);
  logic [1:0] csSync_q;
  logic [1:0] ckSync_q;
  logic csPrev_q;
  logic ckPrev_q;
  logic csN;
  logic ck;
  logic csFall;
  logic csRise;
  logic ckRise;
  logic ckFall;
  logic [4:0] riseCnt_q;
  logic [7:0] ctrl_q;
  logic [7:0] ctrlShift_q;
  logic [15:0] outShift_q;
  logic outBit_q;
  logic outEn_q;
  logic [1:0] power_q;
  logic converting_q;
  logic wakePending_q;
  apm_pkg::apm_mode_e mode;

  // select and clock pins are async to clk: two flops each before use
  always_ff @(posedge clk)
  begin
    csSync_q <= {csSync_q[0], link.selectN};
    ckSync_q <= {ckSync_q[0], link.serialClk};
    csPrev_q <= csSync_q[1];
    ckPrev_q <= ckSync_q[1];
  end

  assign csN = csSync_q[1];
  assign ck = ckSync_q[1];
  assign csFall = csPrev_q & ~csN;
  assign csRise = ~csPrev_q & csN;
  // clock only counts while select is low
  assign ckRise = ~csN & ~ckPrev_q & ck;
  assign ckFall = ~csN & ckPrev_q & ~ck;
  assign mode = apm_pkg::apm_mode_e'(ctrl_q[`APM_PM_HI_POS:`APM_PM_LO_POS]);

  // rising edge count; wraps so a held-low select starts anew
  always_ff @(posedge clk)
  begin
    if (reset || csFall)
      riseCnt_q <= 5'h00;
    else if (ckRise)
      riseCnt_q <= (riseCnt_q == `APM_LAST_EDGE) ? 5'h01 : riseCnt_q + 5'h01;
  end

  // control loads on first eight rising edges every transfer
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      ctrl_q <= `APM_CTRL_RESET;
      ctrlShift_q <= 8'h00;
    end
    else if (ckRise && (riseCnt_q < 5'h08 || riseCnt_q == `APM_LAST_EDGE))
    begin
      ctrlShift_q <= {ctrlShift_q[6:0], link.dataIn};
      if (riseCnt_q == 5'h07)
        ctrl_q <= {ctrlShift_q[6:0], link.dataIn};
    end
  end

  // sample on second rising edge using channel already in ctrl
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      outShift_q <= 16'h0000;
      outBit_q <= 1'b0;
      converting_q <= 1'b0;
    end
    else
    begin
      if (ckRise && riseCnt_q == `APM_SAMPLE_EDGE - 5'h01)
      begin
        // leading bits already on the wire: keep them zero, load result
        outShift_q <= {4'h0, ctrl_q[`APM_CHAN_POS] ? sampleB : sampleA};
        converting_q <= 1'b1;
      end
      else if (ckRise && riseCnt_q == `APM_LAST_EDGE - 5'h01)
        converting_q <= 1'b0;
      else if (csRise)
        converting_q <= 1'b0;
      if (ckFall)
      begin
        // bit n+1 leaves on falling edge n, read on rising n+1
        outBit_q <= outShift_q[4'hF - riseCnt_q[3:0]];
      end
      if (csFall)
        outBit_q <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset || csN)
      outEn_q <= 1'b0;
    else
      outEn_q <= 1'b1;
  end

  // power state per mode
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      power_q <= apm_pkg::APM_OFF;
      wakePending_q <= 1'b0;
    end
    else
    begin
      if (csFall)
        wakePending_q <= 1'b1;
      else if (ckFall)
        wakePending_q <= 1'b0;
      case (mode)
        apm_pkg::APM_SEL_CTRL:
          power_q <= csN ? apm_pkg::APM_OFF : apm_pkg::APM_ON;
        apm_pkg::APM_NORMAL:
          power_q <= apm_pkg::APM_ON;
        apm_pkg::APM_AUTO_SHUT:
        begin
          if (ckRise && riseCnt_q == `APM_LAST_EDGE - 5'h01)
            power_q <= apm_pkg::APM_OFF;
          else if (ckFall && wakePending_q)
            power_q <= apm_pkg::APM_ON;
        end
        default:
        begin
          if (ckRise && riseCnt_q == `APM_LAST_EDGE - 5'h01)
            power_q <= apm_pkg::APM_STANDBY;
          else if (ckFall && wakePending_q)
            power_q <= apm_pkg::APM_ON;
        end
      endcase
    end
  end

  assign link.dataOut = outBit_q;
  assign link.dataOutEn = outEn_q;
  assign powerState = power_q;
  assign powerMode = ctrl_q[`APM_PM_HI_POS:`APM_PM_LO_POS];
  assign tracking = ~csN & (riseCnt_q < `APM_SAMPLE_EDGE);
  assign converting = converting_q;
  assign ctrlValue = ctrl_q;
endmodule : apm_device

/* logic/apm_host.sv */
`timescale 1ns/1ps
`include "apm_cfg.svh"
module apm_host
(
  input wire logic clk,
  input wire logic reset,
  apm_link_if.host link,
  input wire logic start,
  input wire logic [7:0] ctrlWord,
  input wire logic waitWake,
  output logic busy,
  output logic done,
  output logic [11:0] result
);
  typedef enum logic [1:0]
  {
    HST_IDLE = 2'b00,
    HST_WAKE = 2'b01,
    HST_SHIFT = 2'b10,
    HST_END = 2'b11
  } apm_hst_e;
  apm_hst_e state_q;
  logic [12:0] wait_q;
  logic [3:0] div_q;
  logic [4:0] edges_q;
  logic [7:0] ctrl_q;
  logic [15:0] rx_q;
  logic [11:0] result_q;
  logic sck_q;
  logic cs_q;
  logic din_q;
  logic done_q;
  logic [1:0] doSync_q;

  always_ff @(posedge clk)
    doSync_q <= {doSync_q[0], link.dataOut};

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_q <= HST_IDLE;
      cs_q <= 1'b1;
      sck_q <= 1'b1;
      din_q <= 1'b0;
      wait_q <= 13'h0000;
      div_q <= 4'h0;
      edges_q <= 5'h00;
      ctrl_q <= 8'h00;
      rx_q <= 16'h0000;
      result_q <= 12'h000;
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      case (state_q)
        HST_IDLE:
          if (start)
          begin
            cs_q <= 1'b0;
            ctrl_q <= ctrlWord;
            wait_q <= 13'h0000;
            div_q <= 4'h0;
            edges_q <= 5'h00;
            state_q <= HST_SHIFT;
          end
        HST_WAKE:
        begin
          // wait after the first fall: covers both select fall and first fall wake
          wait_q <= wait_q + 13'h0001;
          if (wait_q == 13'(`APM_WAKE_CYC))
            state_q <= HST_SHIFT;
        end
        HST_SHIFT:
        begin
          div_q <= div_q + 4'h1;
          if (div_q == 4'(`APM_HALF_DIV - 1))
          begin
            div_q <= 4'h0;
            sck_q <= ~sck_q;
            if (sck_q)
            begin
              din_q <= ctrl_q[7];
              ctrl_q <= {ctrl_q[6:0], 1'b0};
              if (edges_q == 5'h00 && waitWake)
                state_q <= HST_WAKE;
            end
            else
            begin
              rx_q <= {rx_q[14:0], doSync_q[1]};
              edges_q <= edges_q + 5'h01;
              if (edges_q == `APM_LAST_EDGE - 5'h01)
                state_q <= HST_END;
            end
          end
        end
        default:
        begin
          div_q <= div_q + 4'h1;
          if (div_q == 4'(`APM_HALF_DIV - 1))
          begin
            cs_q <= 1'b1;
            result_q <= rx_q[11:0];
            done_q <= 1'b1;
            state_q <= HST_IDLE;
          end
        end
      endcase
    end
  end

  assign link.selectN = cs_q;
  assign link.serialClk = sck_q;
  assign link.dataIn = din_q;
  assign busy = (state_q != HST_IDLE);
  assign done = done_q;
  assign result = result_q;
endmodule : apm_host

/* verif/apm_link_sva.sv */
`timescale 1ns/1ps
module apm_link_sva
(
  input wire logic clk,
  input wire logic reset,
  input wire logic selectN,
  input wire logic serialClk,
  input wire logic dataIn,
  input wire logic dataOut,
  input wire logic dataOutEn,
  input wire logic [1:0] powerState,
  input wire logic [1:0] powerMode
);
  logic sclkQ;
  logic [4:0] riseCnt;
  logic rise;
  // raw wire edges; the device sees them two clocks later
  assign rise = serialClk & ~sclkQ & ~selectN;
  always_ff @(posedge clk)
    sclkQ <= serialClk;
  always_ff @(posedge clk)
    if (reset || selectN)
      riseCnt <= 5'h00;
    else if (rise)
      riseCnt <= riseCnt + 5'h01;
  default clocking
    @(posedge clk);
  endclocking
  default disable iff (reset);
  sequence lastRise;
    rise && riseCnt == 5'h0F;
  endsequence
  a_float_idle: assert property (selectN [*5] |-> !dataOutEn)
    else $error("data output driven while deselected");
  a_clk_idle: assert property (selectN |-> serialClk)
    else $error("serial clock low outside a frame");
  a_sel_off: assert property ((powerMode == 2'b00 && selectN) [*5] |-> powerState == 2'h0)
    else $error("powered while deselected in select mode");
  a_normal_on: assert property ((powerMode == 2'b01) [*2] |-> powerState == 2'h2)
    else $error("normal mode not powered");
  a_out_stable: assert property (serialClk && dataOutEn && $past(serialClk) && $past(dataOutEn)
    |-> $stable(dataOut))
    else $error("data output moved while serial clock high");
  a_lead_zeros: assert property (rise && riseCnt < 5'h04 |-> !dataOut)
    else $error("leading bit not zero");
  a_sixteen_clk: assert property ($rose(selectN) |-> riseCnt == 5'h10)
    else $error("frame without sixteen rises");
  a_auto_down: assert property (powerMode[1] ##0 lastRise |-> ##[1:6] powerState == {1'b0, powerMode[0]})
    else $error("no power down after conversion");
endmodule : apm_link_sva

/* verif/adc_power_mode_serial_port_tb_top.sv */
`timescale 1ns/1ps
module adc_power_mode_serial_port_tb_top;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic start = 1'b0;
  logic waitWake = 1'b0;
  logic [7:0] ctrlWord = 8'h00;
  logic [11:0] sampleA = 12'h000;
  logic [11:0] sampleB = 12'h000;
  logic busy, done, tracking, converting;
  logic [11:0] result;
  logic [1:0] powerState, powerMode;
  logic [7:0] ctrlValue;
  logic [11:0] expQ[$];
  int bad_count = 0;
  int check_count = 0;
  logic prevChan = 1'b0;
  logic [1:0] prevPm = 2'b00;
  logic [7:0] tbl [6] = '{8'h01, 8'h21, 8'h23, 8'h22, 8'h00, 8'h20};
  always #5 clk = ~clk;
  apm_link_if link ();
  apm_device apm_device_inst (.clk(clk), .reset(reset), .link(link), .sampleA(sampleA), .sampleB(sampleB),
    .powerState(powerState), .powerMode(powerMode), .tracking(tracking), .converting(converting),
    .ctrlValue(ctrlValue));
  apm_host apm_host_inst (.clk(clk), .reset(reset), .link(link), .start(start), .ctrlWord(ctrlWord),
    .waitWake(waitWake), .busy(busy), .done(done), .result(result));
  apm_link_sva apm_link_sva_inst (.clk(clk), .reset(reset), .selectN(link.selectN), .serialClk(link.serialClk),
    .dataIn(link.dataIn), .dataOut(link.dataOut), .dataOutEn(link.dataOutEn), .powerState(powerState),
    .powerMode(powerMode));
  task automatic check(input string name, input logic [11:0] seen, input logic [11:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  task automatic xfer(input logic [7:0] c);
    int n;
    n = 0;
    @(negedge clk);
    sampleA = 12'($urandom);
    sampleB = 12'($urandom);
    ctrlWord = c;
    // only the wake from full shutdown needs the long wait
    waitWake = (prevPm == 2'b00) || (prevPm == 2'b10);
    expQ.push_back(prevChan ? sampleB : sampleA);
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    while (busy !== 1'b0 && n < 3000)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 3000)
    begin
      bad_count++;
      stop_test();
    end
    check("ctrlValue", {4'h0, ctrlValue}, {4'h0, c});
    check("powerMode", {10'h000, powerMode}, {10'h000, c[1:0]});
    prevChan = c[5];
    prevPm = c[1:0];
    $display("transfer with control %h finished", c);
    repeat (9) @(negedge clk);
  endtask : xfer
  always @(negedge clk)
    if (done === 1'b1)
      check("result", result, expQ.pop_front());
  initial
  begin
    void'($urandom(32'h8AAD714A));
    repeat (3) @(negedge clk);
    reset = 1'b0;
    foreach (tbl[i])
      xfer(tbl[i]);
    repeat (4)
      xfer({2'b00, 1'($urandom), 3'h0, 2'($urandom)});
    check("pending", 12'(expQ.size()), 12'h000);
    stop_test();
  end
endmodule : adc_power_mode_serial_port_tb_top
